// File: design/bgp_gpio_port.sv
// Behaviour
// - Three registers per port; sample read-only
// - Global pull-up disable kills every pull-up not under override
// - Direction one is output, zero input
// - Input with drive one enables pull-up
// - Reset tri-states pins asynchronously
// - Output pin drives its drive value bit
// - Without override, pull-up only for input, one, enabled
// - Pin level readable whatever the direction
// - Falling-edge capture then rising-edge sample
// - Written level readable by a read two clocks later
// - Single-bit set and clear of bits
// - Alternate functions leave other pins usable
// - Deep sleep clamps inputs, except interrupts
`timescale 1ns/1ps
`default_nettype none

module bgp_gpio_port
  import bgp_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 2,
  parameter int unsigned IO_ADDR_W = 6
) (
  // Clock and reset
  input  wire logic                               mclk_in,
  input  wire logic                               rst_in,
  // I/O register port
  input  wire logic [IO_ADDR_W-1:0]               io_addr_in,
  input  wire logic                               io_wr_in,
  input  wire logic                               io_rd_in,
  input  wire logic [7:0]                         io_wdata_in,
  output var  logic [7:0]                         io_rdata_out,
  // Single-bit set and clear
  input  wire logic                               bit_set_instruction_in,
  input  wire logic                               bit_clear_instruction_in,
  input  wire logic [2:0]                         bit_index_in,
  // Alternate function overrides, one bit per pin
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_pullup_ovr_en_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_pullup_ovr_val_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_dir_ovr_en_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_dir_ovr_val_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_value_ovr_en_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_value_ovr_val_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_din_ovr_en_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] af_din_ovr_val_in,
  // Sleep control
  input  wire logic                               deep_sleep_in,
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] ext_int_en_in,
  // Pads
  input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0] pad_in,
  output var  logic [NUM_PORTS*PINS_PER_PORT-1:0] pad_out,
  output var  logic [NUM_PORTS*PINS_PER_PORT-1:0] pad_oe_out,
  output var  logic [NUM_PORTS*PINS_PER_PORT-1:0] pad_pullup_out
);

  localparam int unsigned NPIN = NUM_PORTS * PINS_PER_PORT;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Port groups must all sit below the special function register
  if (NUM_PORTS < 1 || NUM_PORTS * REG_STRIDE > int'(SFIO_ADDR)) begin : g_bad_ports
    $error("NUM_PORTS out of range for the register map");
  end
  if (IO_ADDR_W < 6 || IO_ADDR_W > 16) begin : g_bad_addr
    $error("IO_ADDR_W must hold the special function address");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] drive;
    logic [NUM_PORTS-1:0][7:0] dir;
    logic                      pullup_dis;
    logic [7:0]                rdata;
    logic [NPIN-1:0]           pad_out;
    logic [NPIN-1:0]           pad_oe;
    logic [NPIN-1:0]           pull;
  } bgp_state_s;

  bgp_state_s      cur_ff;
  bgp_state_s      nxt_cur;
  logic [NPIN-1:0] sampled;
  logic [NPIN-1:0] din_level;

  // ----------------------------------------------------------------
  // Input path and synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < NPIN; gi++) begin : g_pin
    logic din_en;
    // Clamp floating inputs in deep sleep; interrupt pins stay live
    assign din_en = af_din_ovr_en_in[gi] ? af_din_ovr_val_in[gi]
                                         : !(deep_sleep_in && !ext_int_en_in[gi]);
    assign din_level[gi] = pad_in[gi] & din_en;

    bgp_pin_sync u_sync (
      .mclk_in     (mclk_in),
      .rst_in      (rst_in),
      .level_in    (din_level[gi]),
      .sampled_out (sampled[gi])
    );
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic [IO_ADDR_W-1:0] reg_addr(input int unsigned port,
                                                   input int unsigned ofs);
    reg_addr = IO_ADDR_W'(port * REG_STRIDE + ofs);
  endfunction

  // Write, then set, then clear: whole-byte writes win a same-cycle clash
  function automatic logic [7:0] update(input logic [7:0] old,
                                        input logic       hit);
    logic [7:0] val;
    val = old;
    if (hit && io_wr_in) begin
      val = io_wdata_in;
    end else if (hit && bit_set_instruction_in) begin
      val[bit_index_in] = 1'b1;
    end else if (hit && bit_clear_instruction_in) begin
      val[bit_index_in] = 1'b0;
    end
    update = val;
  endfunction

  always_comb begin
    logic [7:0] sfio;
    int unsigned n;
    sfio    = 8'h00;
    n       = 0;
    nxt_cur = cur_ff;

    // --------------------------------------------------------------
    // Register writes and bit operations
    // --------------------------------------------------------------
    // A bit operation moves only the addressed bit, so other pins keep their setup
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      nxt_cur.dir[p]   = update(cur_ff.dir[p],
                                io_addr_in == reg_addr(p, OFS_DIR));
      nxt_cur.drive[p] = update(cur_ff.drive[p],
                                io_addr_in == reg_addr(p, OFS_DRIVE));
    end
    sfio[PULLUP_DIS_BIT] = cur_ff.pullup_dis;
    sfio                 = update(sfio, io_addr_in == IO_ADDR_W'(SFIO_ADDR));
    nxt_cur.pullup_dis   = sfio[PULLUP_DIS_BIT];

    // --------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------
    if (io_rd_in) begin
      nxt_cur.rdata = UNMAPPED_RD;
      if (io_addr_in == IO_ADDR_W'(SFIO_ADDR)) begin
        nxt_cur.rdata = 8'h00;
        nxt_cur.rdata[PULLUP_DIS_BIT] = cur_ff.pullup_dis;
      end else begin
        for (int unsigned p = 0; p < NUM_PORTS; p++) begin
          if (io_addr_in == reg_addr(p, OFS_SAMPLE)) begin
            nxt_cur.rdata = sampled[p*PINS_PER_PORT +: PINS_PER_PORT];
          end else if (io_addr_in == reg_addr(p, OFS_DIR)) begin
            nxt_cur.rdata = cur_ff.dir[p];
          end else if (io_addr_in == reg_addr(p, OFS_DRIVE)) begin
            nxt_cur.rdata = cur_ff.drive[p];
          end
        end
      end
    end

    // --------------------------------------------------------------
    // Pad control
    // --------------------------------------------------------------
    // Computed from the new register values so pads follow the write edge
    for (int unsigned p = 0; p < NUM_PORTS; p++) begin
      for (int unsigned b = 0; b < PINS_PER_PORT; b++) begin
        n = p * PINS_PER_PORT + b;
        // Overrides are per pin, so other pins of the port stay plain I/O
        nxt_cur.pad_oe[n]  = af_dir_ovr_en_in[n] ? af_dir_ovr_val_in[n]
                                                 : nxt_cur.dir[p][b];
        nxt_cur.pad_out[n] = af_value_ovr_en_in[n] ? af_value_ovr_val_in[n]
                                                   : nxt_cur.drive[p][b];
        nxt_cur.pull[n]    = af_pullup_ovr_en_in[n] ? af_pullup_ovr_val_in[n]
                                                    : (!nxt_cur.dir[p][b] &&
                                                       nxt_cur.drive[p][b] &&
                                                       !nxt_cur.pullup_dis);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Async reset: pads float even with the clock stopped
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_ff.drive  <= {NUM_PORTS{RST_DRIVE}};
      cur_ff.dir    <= {NUM_PORTS{RST_DIR}};
      cur_ff.pullup_dis <= RST_PULLUP_DIS;
      cur_ff.rdata  <= RST_RDATA;
      cur_ff.pad_out <= '0;
      cur_ff.pad_oe <= '0;
      cur_ff.pull   <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata_out   = cur_ff.rdata;
  assign pad_out        = cur_ff.pad_out;
  assign pad_oe_out     = cur_ff.pad_oe;
  assign pad_pullup_out = cur_ff.pull;

endmodule // bgp_gpio_port

`default_nettype wire

// File: design/bgp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bgp_pin_sync (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Pin level and its sampled value
  input  wire logic level_in,
  output var  logic sampled_out
);

  logic latch_ff;

  // ----------------------------------------------------------------
  // Capture stage
  // ----------------------------------------------------------------
  // Closes on the falling edge, as a latch open while the clock is high
  always_ff @(negedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_ff <= 1'b0;
    end else begin
      latch_ff <= level_in;
    end
  end

  // ----------------------------------------------------------------
  // Sampled register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sampled_out <= 1'b0;
    end else begin
      sampled_out <= latch_ff;
    end
  end

endmodule // bgp_pin_sync

`default_nettype wire

// File: design/bgp_pkg.sv
package bgp_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int unsigned PINS_PER_PORT = 8;
  localparam int unsigned REG_STRIDE    = 3;

  // ----------------------------------------------------------------
  // Register offsets within one port's group of three
  // ----------------------------------------------------------------
  localparam int unsigned OFS_SAMPLE = 0;
  localparam int unsigned OFS_DIR    = 1;
  localparam int unsigned OFS_DRIVE  = 2;

  // ----------------------------------------------------------------
  // Special function register and its field
  // ----------------------------------------------------------------
  localparam logic [5:0] SFIO_ADDR   = 6'h30;
  localparam int unsigned PULLUP_DIS_BIT = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DRIVE   = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic       RST_PULLUP_DIS = 1'b0;
  localparam logic [7:0] RST_RDATA   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

endpackage : bgp_pkg

// File: test/bgp_gpio_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bgp_gpio_port_chk
  import bgp_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 2,
  parameter int unsigned IO_ADDR_W = 6
) (
  // Watched ports
  input wire logic                   mclk_in, rst_in, io_wr_in, io_rd_in,
  input wire logic                   bit_set_instruction_in, bit_clear_instruction_in,
  input wire logic [IO_ADDR_W-1:0]   io_addr_in,
  input wire logic [7:0]             io_wdata_in, io_rdata_out,
  input wire logic [2:0]             bit_index_in,
  input wire logic [NUM_PORTS*8-1:0] af_dir_ovr_en_in, af_value_ovr_en_in, af_pullup_ovr_en_in,
  input wire logic [NUM_PORTS*8-1:0] pad_out, pad_oe_out, pad_pullup_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic dir_ok;
  // Port zero only; overrides would mask the register path
  assign dir_ok = io_addr_in == OFS_DIR && af_dir_ovr_en_in[7:0] == 8'h00;
  a_reset_tristate: assert property (disable iff (1'b0) rst_in |-> pad_oe_out == '0 && pad_pullup_out == '0) else $error("pads active in reset");
  a_oe_from_dir: assert property (io_wr_in && dir_ok |=> pad_oe_out[7:0] == $past(io_wdata_in)) else $error("oe differs from dir");
  a_drive_level: assert property (io_wr_in && io_addr_in == OFS_DRIVE && af_value_ovr_en_in[7:0] == 8'h00 |=> (pad_out[7:0] & pad_oe_out[7:0]) == ($past(io_wdata_in) & pad_oe_out[7:0])) else $error("drive level wrong");
  a_pullup_input: assert property ($past(af_pullup_ovr_en_in[7:0]) == 8'h00 && $past(af_dir_ovr_en_in[7:0]) == 8'h00 |-> (pad_pullup_out[7:0] & pad_oe_out[7:0]) == 8'h00) else $error("pullup on output");
  a_pullup_kill: assert property (io_wr_in && io_addr_in == SFIO_ADDR && io_wdata_in[PULLUP_DIS_BIT] && af_pullup_ovr_en_in == '0 |=> pad_pullup_out == '0) else $error("pullup despite disable");
  a_rdata_hold: assert property (!io_rd_in |=> $stable(io_rdata_out)) else $error("rdata moved");
  a_sample_ro: assert property (io_wr_in && io_addr_in == OFS_SAMPLE |=> $stable(pad_oe_out[7:0]) && $stable(pad_out[7:0])) else $error("sample reg written");
  a_bit_set: assert property (bit_set_instruction_in && !io_wr_in && dir_ok |=> pad_oe_out[7:0] == ($past(pad_oe_out[7:0]) | (8'h01 << $past(bit_index_in)))) else $error("bit set wrong");
  a_bit_clear: assert property (bit_clear_instruction_in && !bit_set_instruction_in && !io_wr_in && dir_ok |=> pad_oe_out[7:0] == ($past(pad_oe_out[7:0]) & ~(8'h01 << $past(bit_index_in)))) else $error("bit clear wrong");
endmodule // bgp_gpio_port_chk
bind bgp_gpio_port bgp_gpio_port_chk #(.NUM_PORTS(NUM_PORTS), .IO_ADDR_W(IO_ADDR_W)) bgp_gpio_port_chk_inst (.mclk_in, .rst_in, .io_wr_in, .io_rd_in, .bit_set_instruction_in, .bit_clear_instruction_in, .io_addr_in, .io_wdata_in, .io_rdata_out, .bit_index_in, .af_dir_ovr_en_in, .af_value_ovr_en_in, .af_pullup_ovr_en_in, .pad_out, .pad_oe_out, .pad_pullup_out);
`default_nettype wire

// File: test/bgp_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module bgp_pad_model #(
  parameter int unsigned NPIN = 16
) (
  // Clock, pad controls, outside sources
  input wire logic            mclk_in,
  input wire logic [NPIN-1:0] pad_out, pad_oe_out, pad_pullup_out, ext_en_in, ext_val_in,
  // Resolved level
  output var logic [NPIN-1:0] pad_in
);
  logic [NPIN-1:0] float_ff = '0;
  // An open pin wanders so a stale level never passes for a real one
  always_ff @(posedge mclk_in) float_ff <= ~float_ff;
  // Chip driver wins, then an outside source, then the weak pull-up
  assign #2 pad_in = (pad_oe_out & pad_out) | (~pad_oe_out & ext_en_in & ext_val_in)
                   | (~pad_oe_out & ~ext_en_in & (pad_pullup_out | float_ff));
endmodule // bgp_pad_model
`default_nettype wire

// File: test/bidirectional_gpio_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bgp_gpio_port_tb;
  import bgp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bs = 1'b0, bc = 1'b0, slp = 1'b0;
  logic [5:0]  addr = '0, b;
  logic [7:0]  wdata = '0, x;
  logic [2:0]  idx = '0;
  logic [15:0] dov_en = '0, dov_val = '0, vov_en = '0, vov_val = '0, puo_en = '0, puo_val = '0;
  logic [15:0] int_en = '0, ext_en = '0, ext_val = '0;
  wire logic [7:0]  rdata;
  wire logic [15:0] pin, pout, poe, ppu;
  int          errors = 0, check_count = 0;
  always #5 clk = ~clk;
  bgp_gpio_port bgp_gpio_port_inst (.mclk_in(clk), .rst_in(rst), .io_addr_in(addr), .io_wr_in(wr),
    .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata), .bit_set_instruction_in(bs),
    .bit_clear_instruction_in(bc), .bit_index_in(idx), .af_pullup_ovr_en_in(puo_en),
    .af_pullup_ovr_val_in(puo_val), .af_dir_ovr_en_in(dov_en), .af_dir_ovr_val_in(dov_val),
    .af_value_ovr_en_in(vov_en), .af_value_ovr_val_in(vov_val), .af_din_ovr_en_in(16'h0000),
    .af_din_ovr_val_in(16'h0000), .deep_sleep_in(slp), .ext_int_en_in(int_en), .pad_in(pin),
    .pad_out(pout), .pad_oe_out(poe), .pad_pullup_out(ppu));
  bgp_pad_model bgp_pad_model_inst (.mclk_in(clk), .pad_out(pout), .pad_oe_out(poe),
    .pad_pullup_out(ppu), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_in(pin));
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Called on a falling edge; every strobe is set once per step, so ops run back to back
  task acc(input logic [5:0] a, input logic [3:0] k, input logic [7:0] d, input logic [2:0] i);
    addr = a;
    {bc, bs, rd, wr} = k;
    wdata = d;
    idx = i;
    @(negedge clk);
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e, input string what);
    acc(a, 4'h2, 8'h00, 3'h0);
    chk(rdata, e, what);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(poe | ppu, 16'h0000, "pads after reset");
    rdc(6'h01, RST_DIR, "dir reset");
    rdc(6'h02, RST_DRIVE, "drive reset");
    for (int p = 0; p < 2; p++) begin
      b = 6'(3 * p);
      x = 8'ha5 ^ 8'(p);
      acc(b + 6'h01, 4'h1, x, 3'h0);
      acc(b + 6'h02, 4'h1, 8'h3c, 3'h0);
      rdc(b + 6'h01, x, "dir");
      rdc(b + 6'h02, 8'h3c, "drive");
      chk(poe[p*8+:8], x, "oe");
      chk(ppu[p*8+:8], ~x & 8'h3c, "pullup");
      chk(pout[p*8+:8] & x, 8'h3c & x, "level");
    end
    acc(6'h00, 4'h1, 8'hff, 3'h0);
    rdc(6'h01, 8'ha5, "dir kept");
    rdc(6'h2f, UNMAPPED_RD, "unmapped");
    acc(SFIO_ADDR, 4'h1, 8'h04, 3'h0);
    chk(ppu, 16'h0000, "pud");
    rdc(SFIO_ADDR, 8'h04, "sfio");
    acc(SFIO_ADDR, 4'h1, 8'h00, 3'h0);
    chk(ppu[7:0], 8'h18, "pud off");
    acc(6'h01, 4'h4, 8'h00, 3'h6);
    acc(6'h02, 4'h8, 8'h00, 3'h2);
    rdc(6'h01, 8'he5, "bit set");
    rdc(6'h02, 8'h38, "bit clear");
    acc(6'h01, 4'h1, 8'hff, 3'h0);
    acc(6'h02, 4'h1, 8'h00, 3'h0);
    acc(6'h02, 4'h1, 8'h5a, 3'h0);
    rdc(6'h00, 8'h00, "no gap");
    rdc(6'h00, 8'h5a, "one gap");
    ext_en = 16'hf000;
    ext_val = 16'ha000;
    acc(6'h04, 4'h1, 8'h00, 3'h0);
    acc(6'h05, 4'h1, 8'h0f, 3'h0);
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    rdc(6'h03, 8'haf, "pulled");
    ext_en = 16'hff00;
    ext_val = 16'ha100;
    dov_en[15] = 1'b1;
    dov_val[15] = 1'b1;
    vov_en[15] = 1'b1;
    vov_val[15] = 1'b1;
    puo_en[14] = 1'b1;
    puo_val[14] = 1'b1;
    // Overrides are registered, then the level needs a falling and a rising edge to reach the sample
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    rdc(6'h03, 8'ha1, "driven");
    chk(poe[15:8], 8'h80, "af oe");
    chk(pout[15], 1'b1, "af level");
    chk(ppu[15:8], 8'h4f, "af pullup");
    slp = 1'b1;
    int_en[8] = 1'b1;
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    rdc(6'h03, 8'h01, "sleep clamp");
    acc(6'h00, 4'h0, 8'h00, 3'h0);
    #1 rst = 1'b1;
    #1 chk(poe | ppu, 16'h0000, "async reset");
    end_of_test();
  end
endmodule // bgp_gpio_port_tb
`default_nettype wire
